// *** shared/supervisor_pkg.sv ***
// Constants and types shared by the supply supervisor reset block
package supervisor_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RESET_PULSE_MS = 200;
    localparam int RESET_PULSE_MIN_MS = 140;
    localparam int RESET_PULSE_MAX_MS = 280;
    localparam longint PULSE_CYCLES_L = (longint'(RESET_PULSE_MS) * 1000000000) / CLK_PERIOD_PS;
    localparam int PULSE_CYCLES = int'(PULSE_CYCLES_L);
    localparam int CNT_W = 32;
    localparam int SYNC_STAGES = 2;
    // ==========================================================
    // Reset values
    localparam logic RST_OUT_N_RESET = 1'b0;
    localparam logic PF_FLAG_N_RESET = 1'b0;
    localparam logic SEL_BACKUP_RESET = 1'b0;
    // Synchronizer reset, bit 0 upward: supply low, manual reset idle,
    // sense low, no switch request from either comparator
    localparam logic [4:0] SYNC_INIT = 5'h03;
    // ==========================================================
    // States
    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_EXTEND = 3'b010,
        ST_RUN = 3'b100
    } sup_state_t;
endpackage

// *** hdl/supply_supervisor_reset.sv ***
// Supply supervisor: reset generator, power-fail flag and backup switch select
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1 - Reset low while main supply below trip
// RL2 - Hold reset for pulse time, then release
// RL3 - Timer restarts while supply stays low
// RL4 - Pulse follows either release event
// RL5 - Manual reset low holds, then extends
// RL6 - Manual reset release starts extension timer
// RL7 - Unused manual reset left floating, pulled high; this block has no pull-up, so the pin must be driven
// RL8 - Power-fail flag low when sense low
// RL9 - Unused sense input tied, never floating
// RL10 - Backup mode forces power-fail flag low
// RL11 - Backed output follows main when above trip
// RL12 - Backup only if below trip and higher
// RL13 - Switchover uses comparator hysteresis band
// RL14 - Reset stays defined while backup present
// RL15 - No separate manual reset debounce
// RL16 - Counter timer, synchronized comparator inputs
// RL17 - Backup mode holds reset, ignores manual
module supply_supervisor_reset
#(
    parameter int PULSE_COUNT = supervisor_pkg::PULSE_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic main_below_trip,
    input wire logic manual_reset_input_n,
    input wire logic power_fail_sense_input,
    input wire logic backup_above_main,
    input wire logic main_above_backup,
    output logic reset_out_n,
    output logic power_fail_flag_n,
    output logic backed_supply_output
);
    import supervisor_pkg::*;

    // ==========================================================
    // Reset release
    logic [SYNC_STAGES-1:0] rst_sync_r;
    wire rst_n = rst_sync_r[SYNC_STAGES-1];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= '0;
        end else begin
            rst_sync_r <= {rst_sync_r[SYNC_STAGES-2:0], 1'b1};
        end
    end

    // ==========================================================
    // Input synchronizers, first stage read only by second
    localparam int NIN = 5;
    logic [NIN-1:0] s1_r;
    logic [NIN-1:0] s2_r;
    wire [NIN-1:0] raw_in = {main_above_backup, backup_above_main, power_fail_sense_input,
                             manual_reset_input_n, main_below_trip};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= SYNC_INIT;
            s2_r <= SYNC_INIT;
        end else if (clk_en) begin
            s1_r <= raw_in; // RL16
            s2_r <= s1_r;
        end
    end

    wire below_s = s2_r[0];
    wire mr_n_s = s2_r[1];
    wire pfi_ok_s = s2_r[2];
    wire bk_gt_s = s2_r[3];
    wire mn_gt_s = s2_r[4];

    // ==========================================================
    // Backup switch select with hysteresis: the two comparator
    // outputs carry the +20 mV and -20 mV offsets; between them
    // the previous selection is kept.
    logic sel_backup_r;
    wire sel_backup_nxt = !below_s ? 1'b0 : // RL11
                          (bk_gt_s ? 1'b1 : (mn_gt_s ? 1'b0 : sel_backup_r)); // RL12 RL13

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_backup_r <= SEL_BACKUP_RESET;
        end else if (clk_en) begin
            sel_backup_r <= sel_backup_nxt;
        end
    end

    // ==========================================================
    // Reset pulse state machine
    sup_state_t state_r;
    sup_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // Only the run state lets the processor out of reset
    function automatic logic is_run(sup_state_t s);
        return s == ST_RUN;
    endfunction

    // Manual reset is ignored in backup mode; no debounce, pulse covers bounce
    wire mr_act = !mr_n_s && !sel_backup_r; // RL15 RL17
    wire hold_cond = below_s || mr_act || sel_backup_r; // RL1 RL5
    wire cnt_done = (cnt_r >= CNT_W'(PULSE_COUNT - 1));

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_HOLD: begin
                cnt_nxt = '0; // RL3
                if (!hold_cond) begin
                    state_nxt = ST_EXTEND; // RL4 RL6
                end
            end
            ST_EXTEND: begin
                if (hold_cond) begin
                    state_nxt = ST_HOLD; // RL3
                    cnt_nxt = '0;
                end else if (cnt_done) begin
                    state_nxt = ST_RUN; // RL2
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1); // RL16
                end
            end
            ST_RUN: begin
                cnt_nxt = '0;
                if (hold_cond) begin
                    state_nxt = ST_HOLD; // RL1
                end
            end
            default: begin
                state_nxt = ST_HOLD;
                cnt_nxt = '0;
            end
        endcase
    end

    // Next output values; RUN is the only state with reset released
    wire reset_n_nxt = is_run(state_nxt); // RL14
    wire pf_n_nxt = pfi_ok_s && !sel_backup_nxt; // RL8 RL10

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_HOLD;
            cnt_r <= '0;
            reset_out_n <= RST_OUT_N_RESET;
            power_fail_flag_n <= PF_FLAG_N_RESET;
            backed_supply_output <= SEL_BACKUP_RESET;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            reset_out_n <= reset_n_nxt;
            power_fail_flag_n <= pf_n_nxt;
            backed_supply_output <= sel_backup_nxt;
        end
    end

    // ==========================================================
    // Assertion helper: cycles since the hold condition cleared
    logic [CNT_W-1:0] free_run_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            free_run_r <= '0;
        end else if (clk_en) begin
            if (hold_cond) begin
                free_run_r <= '0;
            end else if (free_run_r != '1) begin
                free_run_r <= free_run_r + CNT_W'(1);
            end
        end
    end

    // ==========================================================
    // Assertions
    a_reset_low_below: assert property (@(posedge mclk) disable iff (!rst_n) // RL1
        (clk_en && below_s) |=> !reset_out_n)
        else $error("reset released while supply below trip");

    a_reset_mr_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RL5
        (clk_en && !mr_n_s) |=> !reset_out_n)
        else $error("reset released while manual reset low");

    a_pulse_length: assert property (@(posedge mclk) disable iff (!rst_n) // RL2
        (clk_en && state_r == ST_EXTEND && cnt_r == '0 && !hold_cond) |=>
        (cnt_r == CNT_W'(1) || !clk_en || state_r != ST_EXTEND))
        else $error("pulse counter not advancing");

    a_release_done: assert property (@(posedge mclk) disable iff (!rst_n) // RL4
        $rose(reset_out_n) |-> $past(cnt_done))
        else $error("reset released before pulse time");

    a_restart_timer: assert property (@(posedge mclk) disable iff (!rst_n) // RL3
        (clk_en && hold_cond) |=> cnt_r == '0)
        else $error("timer not restarted on hold");

    a_pf_backup: assert property (@(posedge mclk) disable iff (!rst_n) // RL10
        backed_supply_output |-> !power_fail_flag_n)
        else $error("power-fail flag high in backup mode");

    a_pf_follow: assert property (@(posedge mclk) disable iff (!rst_n) // RL8
        (clk_en && !pfi_ok_s) |=> !power_fail_flag_n)
        else $error("power-fail flag not low on low sense");

    a_main_select: assert property (@(posedge mclk) disable iff (!rst_n) // RL11
        (clk_en && !below_s) |=> !backed_supply_output)
        else $error("backup selected above trip");

    a_backup_only: assert property (@(posedge mclk) disable iff (!rst_n) // RL12
        $rose(backed_supply_output) |-> $past(below_s && bk_gt_s))
        else $error("backup selected without both conditions");

    a_backup_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RL17
        backed_supply_output |-> !reset_out_n)
        else $error("reset released in backup mode");

    // ==========================================================
    // Pulse timing, selection and freeze checks
    a_release_exact: assert property (@(posedge mclk) disable iff (!rst_n) // RL2
        $rose(reset_out_n) |-> free_run_r == CNT_W'(PULSE_COUNT + 1))
        else $error("reset released after wrong pulse length");

    a_release_gap: assert property (@(posedge mclk) disable iff (!rst_n) // RL4
        reset_out_n |-> free_run_r >= CNT_W'(PULSE_COUNT + 1))
        else $error("reset high without a full quiet pulse time");

    a_extend_count: assert property (@(posedge mclk) disable iff (!rst_n) // RL16
        (clk_en && state_r == ST_EXTEND && !hold_cond && !cnt_done) |=>
        (cnt_r == $past(cnt_r) + CNT_W'(1)))
        else $error("pulse counter skipped a cycle");

    a_dip_restart: assert property (@(posedge mclk) disable iff (!rst_n) // RL3
        (clk_en && hold_cond && state_r == ST_EXTEND) |=> state_r == ST_HOLD)
        else $error("dip during pulse did not restart it");

    a_below_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RL1
        (clk_en && below_s) |=> state_r == ST_HOLD)
        else $error("supply low but timer not held");

    a_mr_release: assert property (@(posedge mclk) disable iff (!rst_n) // RL6
        (clk_en && state_r == ST_HOLD && $rose(mr_n_s) && !below_s && !sel_backup_r) |=>
        state_r == ST_EXTEND)
        else $error("manual reset release did not start the pulse");

    a_pf_high: assert property (@(posedge mclk) disable iff (!rst_n) // RL8
        (clk_en && pfi_ok_s && !sel_backup_nxt) |=> power_fail_flag_n)
        else $error("power-fail flag low with sense above reference");

    a_pf_forced: assert property (@(posedge mclk) disable iff (!rst_n) // RL10
        (clk_en && sel_backup_nxt) |=> !power_fail_flag_n)
        else $error("power-fail flag not forced low on backup entry");

    a_backup_enter: assert property (@(posedge mclk) disable iff (!rst_n) // RL12
        (clk_en && below_s && bk_gt_s) |=> backed_supply_output)
        else $error("backup not selected with both conditions");

    a_band_keep: assert property (@(posedge mclk) disable iff (!rst_n) // RL13
        (clk_en && below_s && !bk_gt_s && !mn_gt_s) |=> $stable(backed_supply_output))
        else $error("selection changed inside hysteresis band");

    a_main_return: assert property (@(posedge mclk) disable iff (!rst_n) // RL13
        (clk_en && mn_gt_s && !bk_gt_s) |=> !backed_supply_output)
        else $error("main not restored above backup");

    a_select_track: assert property (@(posedge mclk) disable iff (!rst_n) // RL11
        backed_supply_output == sel_backup_r)
        else $error("switch output differs from selection");

    a_out_state: assert property (@(posedge mclk) disable iff (!rst_n) // RL14
        reset_out_n == is_run(state_r))
        else $error("reset output not defined by state");

    a_state_onehot: assert property (@(posedge mclk) disable iff (!rst_n) // RL14
        $onehot(state_r))
        else $error("state register not one-hot");

    a_count_range: assert property (@(posedge mclk) disable iff (!rst_n) // RL16
        cnt_r <= CNT_W'(PULSE_COUNT - 1))
        else $error("pulse counter beyond terminal count");

    a_freeze_out: assert property (@(posedge mclk) disable iff (!rst_n) // RL16
        !clk_en |=> ($stable(reset_out_n) && $stable(power_fail_flag_n) &&
        $stable(backed_supply_output)))
        else $error("output changed while clock enable low");

    a_freeze_count: assert property (@(posedge mclk) disable iff (!rst_n) // RL16
        !clk_en |=> ($stable(cnt_r) && $stable(state_r)))
        else $error("timer moved while clock enable low");

    a_backup_mr: assert property (@(posedge mclk) disable iff (!rst_n) // RL17
        (clk_en && sel_backup_r && state_r == ST_HOLD) |=> state_r == ST_HOLD)
        else $error("pulse started during backup mode");

    // ==========================================================
    // Scenario covers

    c_power_up: cover property (@(posedge mclk) disable iff (!rst_n) $rose(reset_out_n));
    c_brownout: cover property (@(posedge mclk) disable iff (!rst_n)
        state_r == ST_EXTEND ##1 state_r == ST_HOLD);
    c_backup: cover property (@(posedge mclk) disable iff (!rst_n) $rose(backed_supply_output));
    c_manual: cover property (@(posedge mclk) disable iff (!rst_n)
        reset_out_n ##1 (!mr_n_s));
    c_freeze: cover property (@(posedge mclk) disable iff (!rst_n)
        !clk_en && state_r == ST_EXTEND);
endmodule
`default_nettype wire

// *** tb/proc_side_model.sv ***
// Processor-side model: pushbutton on the manual reset pin
`timescale 1ns/1ps
`default_nettype none
module proc_side_model (
    input wire logic button_pressed,
    output logic manual_reset_input_n
);
    // A released button drives the pin high itself, as the block has no pull-up
    assign manual_reset_input_n = button_pressed ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// *** tb/supply_supervisor_reset_tb.sv ***
// Self-checking bench for the supply supervisor reset block
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_reset_tb;
    // ==========================================
    // Short pulse so the run stays brief
    localparam int PC = 20;
    logic mclk = 0, nrst = 0, below = 1, btn = 0, sense = 1, bup = 0, mup = 0, en = 1;
    wire logic mr_n, rst_n, pf_n, bk;
    int fail_count = 0, n_checks = 0;
    always #4 mclk = ~mclk;
    proc_side_model proc_side_model_inst (.button_pressed(btn), .manual_reset_input_n(mr_n));
    supply_supervisor_reset #(.PULSE_COUNT(PC)) supply_supervisor_reset_inst (
        .mclk(mclk), .nrst(nrst), .clk_en(en), .main_below_trip(below),
        .manual_reset_input_n(mr_n), .power_fail_sense_input(sense),
        .backup_above_main(bup), .main_above_backup(mup), .reset_out_n(rst_n),
        .power_fail_flag_n(pf_n), .backed_supply_output(bk));
    // ==========================================
    // Helpers
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Cycles from a release until reset goes high, bounded
    task automatic pulse_len(output int n);
        n = 0;
        while (rst_n !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic power_up();
        int n;
        tick(10);
        chk("reset_hold", rst_n, 0);
        below = 0;
        pulse_len(n);
        chk("pulse_len", (n > PC && n <= PC + 6), 1);
    endtask
    task automatic pfail();
        sense = 0;
        tick(4);
        chk("pf_low", pf_n, 0);
        sense = 1;
        tick(4);
        chk("pf_high", pf_n, 1);
    endtask
    // Dip during the pulse must give a whole new pulse
    task automatic brownout();
        int n;
        below = 1;
        tick(4);
        chk("brown_hold", rst_n, 0);
        below = 0;
        tick(PC / 2);
        below = 1;
        tick(3);
        below = 0;
        pulse_len(n);
        chk("restart_len", (n > PC && n <= PC + 6), 1);
    endtask
    task automatic manual();
        int n;
        btn = 1;
        tick(PC + 10);
        chk("mr_hold", rst_n, 0);
        btn = 0;
        pulse_len(n);
        chk("mr_pulse", (n > PC && n <= PC + 6), 1);
    endtask
    task automatic backup();
        bup = 1;
        tick(4);
        chk("bk_above_trip", bk, 0);
        below = 1;
        tick(4);
        chk("bk_sel", {bk, pf_n, rst_n}, 3'b100);
        btn = 1;
        tick(4);
        btn = 0;
        bup = 0;
        tick(PC + 8);
        chk("bk_band", {bk, rst_n}, 2'b10);
        mup = 1;
        tick(4);
        chk("bk_back", {bk, pf_n}, 2'b01);
        mup = 0;
        below = 0;
        tick(PC + 8);
        chk("bk_end", rst_n, 1);
    endtask
    // Clock enable low in mid-pulse must stretch it by the frozen span
    task automatic freeze();
        int n;
        below = 1;
        tick(4);
        below = 0;
        tick(6);
        en = 0;
        tick(PC + 10);
        chk("en_frozen", rst_n, 0);
        en = 1;
        pulse_len(n);
        chk("en_resume", n, PC - 3);
    endtask
    // Reset in mid-run: outputs cleared, then a full pulse after release
    task automatic rst_mid();
        int n;
        nrst = 0;
        tick(2);
        chk("rst_vals", {rst_n, pf_n, bk}, 3'h0);
        nrst = 1;
        tick(2);
        chk("rst_wait", rst_n, 0);
        pulse_len(n);
        chk("rst_pulse", n, PC + 3);
    endtask
    // ==========================================
    initial begin
        tick(4);
        nrst = 1;
        power_up();
        pfail();
        brownout();
        manual();
        backup();
        freeze();
        rst_mid();
        final_report();
    end
    initial begin
        #20000;
        fail_count++;
        final_report();
    end
endmodule
`default_nettype wire
